// ---- hdl/cursor_pkg.sv ----
// Notes on behaviour
// - Bit 14 picks trickle or burst requests
// - Bits 11:10 choose planes for alpha forcing
// - Bits 9:8 threshold forces opaque or transparent
// - Mode is bit5 with bits 2:0
// - Bit5 clear: 32bpp and/invert three sizes
// - And/invert: ones show, zeros clear, else invert
// - Bit5 clear: three 2bpp indexed modes
// - Bit5 set: 32bpp alpha format three sizes
// - Bit5 set: 32bpp and/xor three sizes
// - Clamp underlying colour before any combining
// - Base write arms pending control values
// - Base bits 31:12 give 4K-aligned address
// - Rotation fetches 32bpp from last pixel backwards
// - Base, position, palette update at vblank
// - Position is sign-magnitude, upper-left corner
// - Position measured from pipe source corner
// - Rotation leaves programmed position untouched
// - Palette entry holds red, green, blue bytes
// - Index mapping differs per indexed mode
// - Control takes effect when armed and updating
// - Bits 26 and 24 route gamma, CSC
package cursor_pkg;
	// Register byte addresses
	localparam logic [19:0] CTL_ADDR = 20'h70080;
	localparam logic [19:0] BASE_ADDR = 20'h70084;
	localparam logic [19:0] POS_ADDR = 20'h70088;
	localparam logic [19:0] PAL_ADDR = 20'h70090;
	// Writable bits; everything else reads as zero
	localparam logic [31:0] CTL_MASK = 32'h0500cf27;
	localparam logic [31:0] BASE_MASK = 32'hfffff000;
	localparam logic [31:0] POS_MASK = 32'h8fff8fff;
	localparam logic [31:0] PAL_MASK = 32'h00ffffff;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	// Control field positions
	localparam int CTL_GAMMA = 26;
	localparam int CTL_CSC = 24;
	localparam int CTL_ROT = 15;
	localparam int CTL_BURST = 14;
	localparam int CTL_FAP_HI = 11;
	localparam int CTL_FAP_LO = 10;
	localparam int CTL_FAV_HI = 9;
	localparam int CTL_FAV_LO = 8;
	localparam int CTL_MODE5 = 5;
	localparam int CTL_MODE_HI = 2;
	// Forced alpha thresholds
	localparam logic [7:0] FA_50 = 8'h80;
	localparam logic [7:0] FA_75 = 8'hc0;
	localparam logic [7:0] FA_100 = 8'hff;
	localparam logic [7:0] ALPHA_ONE = 8'hff;
	// Fetch granule and request counts per surface
	localparam int CHUNK_SHIFT = 6;
	localparam logic [12:0] CHUNKS_2BPP = 13'h0010;
	localparam logic [12:0] CHUNKS_64 = 13'h0100;
	localparam logic [12:0] CHUNKS_128 = 13'h0400;
	localparam logic [12:0] CHUNKS_256 = 13'h1000;
	localparam logic [3:0] BURST_LEN = 4'h8;

	typedef enum logic [2:0] {FMT_OFF, FMT_AND_INV, FMT_IDX3, FMT_IDX_XOR, FMT_IDX4, FMT_ALPHA_RGB_FORMAT, FMT_AND_XOR} fmt_t;
	typedef enum logic [1:0] {SZ_64, SZ_128, SZ_256} dim_t;
	typedef struct packed {fmt_t fmt; dim_t dim;} mode_t;
	typedef struct packed {logic [7:0] r; logic [7:0] g; logic [7:0] b;} rgb_t;
	typedef struct packed {logic signed [9:0] r; logic signed [9:0] g; logic signed [9:0] b;} wide_rgb_t;
	typedef struct packed {logic y_neg; logic [11:0] y_mag; logic x_neg; logic [11:0] x_mag;} pos_t;

	// Mode select decode; reserved codes behave as disabled
	function automatic mode_t decode_mode(input logic hi, input logic [2:0] lo);
		mode_t m;
		m.fmt = FMT_OFF;
		m.dim = SZ_64;
		case ({hi, lo})
			4'b0010: begin m.fmt = FMT_AND_INV; m.dim = SZ_128; end
			4'b0011: begin m.fmt = FMT_AND_INV; m.dim = SZ_256; end
			4'b0100: m.fmt = FMT_IDX3;
			4'b0101: m.fmt = FMT_IDX_XOR;
			4'b0110: m.fmt = FMT_IDX4;
			4'b0111: m.fmt = FMT_AND_INV;
			4'b1010: begin m.fmt = FMT_ALPHA_RGB_FORMAT; m.dim = SZ_128; end
			4'b1011: begin m.fmt = FMT_ALPHA_RGB_FORMAT; m.dim = SZ_256; end
			4'b1100: m.fmt = FMT_AND_XOR;
			4'b1101: begin m.fmt = FMT_AND_XOR; m.dim = SZ_128; end
			4'b1110: begin m.fmt = FMT_AND_XOR; m.dim = SZ_256; end
			4'b1111: m.fmt = FMT_ALPHA_RGB_FORMAT;
			default: m.fmt = FMT_OFF;
		endcase
		return m;
	endfunction

	function automatic logic is_indexed(input fmt_t f);
		return (f == FMT_IDX3) || (f == FMT_IDX_XOR) || (f == FMT_IDX4);
	endfunction

	function automatic logic [12:0] chunk_count(input mode_t m);
		logic [12:0] n;
		n = CHUNKS_64;
		if (m.fmt == FMT_OFF)
			n = 13'h0000;
		else if (is_indexed(m.fmt))
			n = CHUNKS_2BPP;
		else if (m.dim == SZ_128)
			n = CHUNKS_128;
		else if (m.dim == SZ_256)
			n = CHUNKS_256;
		return n;
	endfunction

	function automatic logic [7:0] clamp8(input logic signed [9:0] v);
		logic [7:0] c;
		c = v[7:0];
		if (v < 10'sd0)
			c = 8'h00;
		else if (v > 10'sd255)
			c = 8'hff;
		return c;
	endfunction
endpackage

// ---- hdl/cursor_pixel_merge.sv ----
`timescale 1ns/1ps
module cursor_pixel_merge (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire cursor_pkg::fmt_t fmt,
	input wire logic [1:0] fa_plane,
	input wire logic [1:0] fa_val,
	input wire cursor_pkg::rgb_t [3:0] pal,
	input wire logic pix_valid,
	input wire logic pix_in_cursor,
	input wire logic [31:0] cur_texel,
	input wire cursor_pkg::wide_rgb_t under_pix,
	input wire logic under_sprite,
	input wire logic under_primary,
	output logic out_valid,
	output cursor_pkg::rgb_t out_pix
);
	cursor_pkg::rgb_t und;
	cursor_pkg::rgb_t col;
	cursor_pkg::rgb_t nxt_pix;
	logic [7:0] alpha;
	logic [7:0] thr;
	logic plane_hit;

	// Divide-by-255 blend; the shortcut is exact at alpha 0 and 255
	function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] c, input logic [7:0] u);
		logic [16:0] t;
		t = 17'(a * c) + 17'((8'hff - a) * u);
		t = t + (t >> 8) + 17'h00001;
		return t[15:8];
	endfunction

	// Underlying colour is clamped first so invert and XOR stay in range
	always_comb begin
		und.r = cursor_pkg::clamp8(under_pix.r);
		und.g = cursor_pkg::clamp8(under_pix.g);
		und.b = cursor_pkg::clamp8(under_pix.b);
		col = cursor_pkg::rgb_t'(cur_texel[23:0]);
		alpha = cur_texel[31:24];
		plane_hit = (fa_plane[0] && under_sprite) || (fa_plane[1] && under_primary);
		case (fa_val)
			2'b01: thr = cursor_pkg::FA_50;
			2'b10: thr = cursor_pkg::FA_75;
			default: thr = cursor_pkg::FA_100;
		endcase
		if (fa_val != 2'b00 && plane_hit)
			alpha = (alpha >= thr) ? cursor_pkg::ALPHA_ONE : 8'h00;
		nxt_pix = und;
		if (pix_in_cursor) begin
			case (fmt)
				cursor_pkg::FMT_AND_INV: begin
					if (cur_texel[31:24] == 8'hff)
						nxt_pix = col;
					else if (cur_texel[31:24] != 8'h00)
						nxt_pix = ~und;
				end
				cursor_pkg::FMT_AND_XOR: begin
					if (cur_texel[31:24] == 8'hff)
						nxt_pix = col;
					else if (cur_texel[31:24] != 8'h00)
						nxt_pix = col ^ und;
				end
				cursor_pkg::FMT_ALPHA_RGB_FORMAT: begin
					nxt_pix.r = blend(alpha, col.r, und.r);
					nxt_pix.g = blend(alpha, col.g, und.g);
					nxt_pix.b = blend(alpha, col.b, und.b);
				end
				cursor_pkg::FMT_IDX3, cursor_pkg::FMT_IDX4: begin
					if (!(fmt == cursor_pkg::FMT_IDX3 && cur_texel[1:0] == 2'b10))
						nxt_pix = pal[cur_texel[1:0]];
				end
				cursor_pkg::FMT_IDX_XOR: begin
					// Inversion relies on palette 3 being all ones
					if (cur_texel[1:0] == 2'b11)
						nxt_pix = und ^ pal[3];
					else if (cur_texel[1:0] != 2'b10)
						nxt_pix = pal[cur_texel[1:0]];
				end
				default: nxt_pix = und;
			endcase
		end
	end

	// One registered stage toward the pipe
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			out_valid <= 1'b0;
			out_pix <= '0;
		end else begin
			out_valid <= pix_valid;
			out_pix <= nxt_pix;
		end
	end
endmodule // cursor_pixel_merge

// ---- hdl/display_cursor_plane.sv ----
`timescale 1ns/1ps
module display_cursor_plane (
	input wire logic sys_clk,
	input wire logic rstn,
	// Memory-mapped register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [19:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// Pipe timing
	input wire logic vblank_start,
	input wire logic pipe_en,
	// Display data buffer and memory requests
	input wire logic dbuf_space,
	input wire logic dbuf_burst_room,
	input wire logic fetch_ack,
	output logic fetch_req,
	output logic [31:0] fetch_addr,
	// Pixel path
	input wire logic pix_valid,
	input wire logic pix_in_cursor,
	input wire logic [31:0] cur_texel,
	input wire cursor_pkg::wide_rgb_t under_pix,
	input wire logic under_sprite,
	input wire logic under_primary,
	output logic out_valid,
	output cursor_pkg::rgb_t out_pix,
	// Active state toward the pipe
	output cursor_pkg::pos_t cursor_pos,
	output logic gamma_en,
	output logic csc_en,
	output logic rotate_180
);
	typedef enum logic {F_IDLE, F_RUN} fetch_state_t;

	logic [31:0] pend_ctl_ff;
	logic [31:0] act_ctl_ff;
	logic [31:0] pend_base_ff;
	logic [31:0] act_base_ff;
	logic [31:0] pend_pos_ff;
	logic [31:0] act_pos_ff;
	cursor_pkg::rgb_t [3:0] pend_pal_ff;
	cursor_pkg::rgb_t [3:0] act_pal_ff;
	logic armed_ff;
	logic [31:0] rdata_ff;
	logic rvalid_ff;
	logic [31:0] nxt_rdata;

	fetch_state_t fstate_ff;
	logic [12:0] chunk_ff;
	logic [12:0] total_ff;
	logic [3:0] burst_left_ff;
	logic req_ff;
	logic [31:0] addr_ff;
	logic frame_go_ff;
	// Combinational helpers for decode, update points and fetch address

	logic hit_ctl;
	logic hit_base;
	logic hit_pos;
	logic hit_pal;
	logic [1:0] pal_idx;
	logic upd_now;
	logic ctl_upd;
	cursor_pkg::mode_t act_mode;
	logic rot_eff;
	logic [12:0] nxt_chunk;
	logic [12:0] offs;
	logic [31:0] nxt_addr;

	// Address decode; palette takes four consecutive words
	assign hit_ctl = (reg_addr == cursor_pkg::CTL_ADDR);
	assign hit_base = (reg_addr == cursor_pkg::BASE_ADDR);
	assign hit_pos = (reg_addr == cursor_pkg::POS_ADDR);
	assign hit_pal = (reg_addr[19:4] == cursor_pkg::PAL_ADDR[19:4]) && (reg_addr[1:0] == 2'b00);
	assign pal_idx = reg_addr[3:2];

	// Update points: start of vertical blank, or at once while the pipe is off
	assign upd_now = vblank_start || !pipe_en;
	assign act_mode = cursor_pkg::decode_mode(act_ctl_ff[cursor_pkg::CTL_MODE5],
		act_ctl_ff[cursor_pkg::CTL_MODE_HI:0]);
	// Control also lands while the live cursor is off, but only once armed
	assign ctl_upd = armed_ff && (upd_now || act_mode.fmt == cursor_pkg::FMT_OFF);

	// Pending control; reserved bits are dropped on write
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pend_ctl_ff <= cursor_pkg::REG_RESET;
		end else if (reg_wr && hit_ctl) begin
			pend_ctl_ff <= reg_wdata & cursor_pkg::CTL_MASK;
		end
	end

	// Pending base; a write here is also the arming event
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pend_base_ff <= cursor_pkg::REG_RESET;
		end else if (reg_wr && hit_base) begin
			pend_base_ff <= reg_wdata & cursor_pkg::BASE_MASK;
		end
	end

	// Pending position, sign-magnitude fields kept as written
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pend_pos_ff <= cursor_pkg::REG_RESET;
		end else if (reg_wr && hit_pos) begin
			pend_pos_ff <= reg_wdata & cursor_pkg::POS_MASK;
		end
	end

	// Pending palette; top byte is reserved and never stored
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pend_pal_ff <= '0;
		end else if (reg_wr && hit_pal) begin
			pend_pal_ff[pal_idx] <= cursor_pkg::rgb_t'(reg_wdata[23:0]);
		end
	end

	// Arm flag: a base write in the transfer cycle keeps it set, so
	// the newer control still waits for the following update point
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			armed_ff <= 1'b0;
		end else if (reg_wr && hit_base) begin
			armed_ff <= 1'b1;
		end else if (ctl_upd) begin
			armed_ff <= 1'b0;
		end
	end

	// Active control copy, moved only as an armed group
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			act_ctl_ff <= cursor_pkg::REG_RESET;
		end else if (ctl_upd) begin
			act_ctl_ff <= pend_ctl_ff;
		end
	end

	// Active base, position and palette follow the plain update point
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			act_base_ff <= cursor_pkg::REG_RESET;
			act_pos_ff <= cursor_pkg::REG_RESET;
			act_pal_ff <= '0;
		end else if (upd_now) begin
			act_base_ff <= pend_base_ff;
			act_pos_ff <= pend_pos_ff;
			act_pal_ff <= pend_pal_ff;
		end
	end

	// Read-back shows the written values, not the active ones
	always_comb begin
		nxt_rdata = 32'h00000000;
		if (hit_ctl)
			nxt_rdata = pend_ctl_ff;
		else if (hit_base)
			nxt_rdata = pend_base_ff;
		else if (hit_pos)
			nxt_rdata = pend_pos_ff;
		else if (hit_pal)
			nxt_rdata = {8'h00, pend_pal_ff[pal_idx]};
	end

	// Read answer one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rdata_ff <= 32'h00000000;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd;
			if (reg_rd)
				rdata_ff <= nxt_rdata;
		end
	end

	// Frame start is delayed a cycle so the fetch sees the fresh active copy
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			frame_go_ff <= 1'b0;
		end else begin
			frame_go_ff <= vblank_start;
		end
	end

	// Fetch ignores rotation for 2bpp formats, which may not be rotated; rotate_180 still passes the bit
	assign rot_eff = act_ctl_ff[cursor_pkg::CTL_ROT] && !cursor_pkg::is_indexed(act_mode.fmt);
	assign nxt_chunk = chunk_ff + 13'h0001;
	// Rotated walk starts at the granule holding the last pixel of the last line
	assign offs = rot_eff ? 13'(total_ff - 13'h0001 - chunk_ff) : chunk_ff;
	// Base address itself is never rewritten; rotation only shifts the offset
	assign nxt_addr = {act_base_ff[31:12], 12'h000} + {13'h0000, offs, 6'h00};

	// Fetch sequencer: one request outstanding, held until acknowledged.
	// Burst mode waits for room for a whole burst, trading latency for
	// fewer, longer memory sessions.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			fstate_ff <= F_IDLE;
			chunk_ff <= 13'h0000;
			total_ff <= 13'h0000;
			burst_left_ff <= 4'h0;
			req_ff <= 1'b0;
			addr_ff <= 32'h00000000;
		end else begin
			case (fstate_ff)
				F_IDLE: begin
					req_ff <= 1'b0;
					if (frame_go_ff && act_mode.fmt != cursor_pkg::FMT_OFF) begin
						fstate_ff <= F_RUN;
						chunk_ff <= 13'h0000;
						total_ff <= cursor_pkg::chunk_count(act_mode);
						burst_left_ff <= 4'h0;
					end
				end
				F_RUN: begin
					if (act_mode.fmt == cursor_pkg::FMT_OFF) begin
						fstate_ff <= F_IDLE;
						req_ff <= 1'b0;
					end else if (req_ff) begin
						if (fetch_ack) begin
							req_ff <= 1'b0;
							chunk_ff <= nxt_chunk;
							if (nxt_chunk == total_ff)
								fstate_ff <= F_IDLE;
						end
					end else if (!act_ctl_ff[cursor_pkg::CTL_BURST]) begin
						if (dbuf_space) begin
							req_ff <= 1'b1;
							addr_ff <= nxt_addr;
						end
					end else if (burst_left_ff != 4'h0) begin
						if (dbuf_space) begin
							req_ff <= 1'b1;
							addr_ff <= nxt_addr;
							burst_left_ff <= burst_left_ff - 4'h1;
						end
					end else if (dbuf_burst_room) begin
						req_ff <= 1'b1;
						addr_ff <= nxt_addr;
						burst_left_ff <= cursor_pkg::BURST_LEN - 4'h1;
					end
				end
				default: begin
					fstate_ff <= F_IDLE;
					req_ff <= 1'b0;
				end
			endcase
		end
	end

	// Pixel combining on the active copies; forced alpha is meaningful
	// only for the alpha formats, others simply ignore the fields
	cursor_pixel_merge merge_u (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.fmt(act_mode.fmt),
		.fa_plane(act_ctl_ff[cursor_pkg::CTL_FAP_HI:cursor_pkg::CTL_FAP_LO]),
		.fa_val(act_ctl_ff[cursor_pkg::CTL_FAV_HI:cursor_pkg::CTL_FAV_LO]),
		.pal(act_pal_ff),
		.pix_valid(pix_valid),
		.pix_in_cursor(pix_in_cursor),
		.cur_texel(cur_texel),
		.under_pix(under_pix),
		.under_sprite(under_sprite),
		.under_primary(under_primary),
		.out_valid(out_valid),
		.out_pix(out_pix)
	);

	// Outputs straight from the registers above
	assign reg_rdata = rdata_ff;
	assign reg_rvalid = rvalid_ff;
	assign fetch_req = req_ff;
	assign fetch_addr = addr_ff;
	assign gamma_en = act_ctl_ff[cursor_pkg::CTL_GAMMA];
	assign csc_en = act_ctl_ff[cursor_pkg::CTL_CSC];
	assign rotate_180 = act_ctl_ff[cursor_pkg::CTL_ROT];
	// Position goes out as programmed, relative to the source upper-left,
	// and is not mirrored under rotation; software compensates
	assign cursor_pos.y_neg = act_pos_ff[31];
	assign cursor_pos.y_mag = act_pos_ff[27:16];
	assign cursor_pos.x_neg = act_pos_ff[15];
	assign cursor_pos.x_mag = act_pos_ff[11:0];
	// Sign bits pass unchanged; the pipe resolves negative offsets
endmodule // display_cursor_plane

// ---- sim/display_cursor_plane_monitor.sv ----
`timescale 1ns/1ps
module display_cursor_plane_monitor (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [19:0] reg_addr,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic vblank_start,
	input wire logic pipe_en,
	input wire logic fetch_ack,
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	input wire logic pix_valid,
	input wire logic out_valid,
	input wire cursor_pkg::pos_t cursor_pos,
	input wire logic gamma_en,
	input wire logic csc_en,
	input wire logic rotate_180
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic arm_ff;
	logic arm_d_ff;
	// Shadow arm flag; it may stay set longer than the real one, which only weakens the check
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			arm_ff <= 1'b0;
			arm_d_ff <= 1'b0;
		end else begin
			arm_d_ff <= arm_ff;
			if (reg_wr && reg_addr == cursor_pkg::BASE_ADDR)
				arm_ff <= 1'b1;
			else if (vblank_start || !pipe_en)
				arm_ff <= 1'b0;
		end
	end
	// Checks on the register port, fetch handshake, pixel timing, position and control updates
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read without answer");
	a_no_stray_answer: assert property (!reg_rd |=> !reg_rvalid)
		else $error("answer without read");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_req_held: assert property (fetch_req && !fetch_ack && !vblank_start && pipe_en |=>
		fetch_req && $stable(fetch_addr))
		else $error("request dropped or moved before ack");
	a_req_gap: assert property (fetch_req && fetch_ack |=> !fetch_req)
		else $error("no gap after ack");
	a_addr_granule: assert property (fetch_req |-> fetch_addr[5:0] == 6'h00)
		else $error("fetch address not on granule");
	a_pixel_delay: assert property (1'b1 |-> out_valid == $past(pix_valid))
		else $error("pixel result not one cycle after strobe");
	a_pos_steady: assert property (!vblank_start && pipe_en && !$past(vblank_start) && $past(pipe_en)
		|=> $stable(cursor_pos))
		else $error("position changed outside update point");
	a_ctl_needs_arm: assert property (!arm_ff && !arm_d_ff |=> $stable({gamma_en, csc_en, rotate_180}))
		else $error("control changed without arming");
	c_read: cover property (reg_rd ##1 reg_rvalid);
	c_fetch: cover property (fetch_req && fetch_ack);
	c_pixel: cover property (pix_valid ##1 out_valid);
endmodule // display_cursor_plane_monitor

bind display_cursor_plane display_cursor_plane_monitor mon (.sys_clk, .rstn, .reg_wr, .reg_rd, .reg_addr,
	.reg_rdata, .reg_rvalid, .vblank_start, .pipe_en, .fetch_ack, .fetch_req, .fetch_addr, .pix_valid,
	.out_valid, .cursor_pos, .gamma_en, .csc_en, .rotate_180);

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	localparam cursor_pkg::wide_rgb_t U = {10'h011, 10'h022, 10'h033};
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [19:0] reg_addr = 20'h00000;
	logic [31:0] reg_wdata = 32'h00000000;
	logic [31:0] reg_rdata;
	logic reg_rvalid;
	logic vblank_start = 1'b0;
	logic pipe_en = 1'b1;
	logic dbuf_space = 1'b0;
	logic dbuf_burst_room = 1'b0;
	logic fetch_ack = 1'b0;
	logic fetch_req;
	logic [31:0] fetch_addr;
	logic pix_valid = 1'b0;
	logic pix_in_cursor = 1'b0;
	logic [31:0] cur_texel = 32'h00000000;
	cursor_pkg::wide_rgb_t under_pix = U;
	logic under_sprite = 1'b0;
	logic under_primary = 1'b0;
	logic out_valid;
	cursor_pkg::rgb_t out_pix;
	cursor_pkg::pos_t cursor_pos;
	logic gamma_en;
	logic csc_en;
	logic rotate_180;
	int errors = 0;
	int n_checks = 0;
	logic [19:0] adr [7] = '{20'h70080, 20'h70084, 20'h70088, 20'h70090, 20'h70094, 20'h70098, 20'h7009c};
	logic [31:0] msk [7] = '{cursor_pkg::CTL_MASK, cursor_pkg::BASE_MASK, cursor_pkg::POS_MASK,
		cursor_pkg::PAL_MASK, cursor_pkg::PAL_MASK, cursor_pkg::PAL_MASK, cursor_pkg::PAL_MASK};
	// Entry 3 is all ones so the two-colour mode really inverts
	logic [31:0] pal [4] = '{32'h00102030, 32'h00405060, 32'h00708090, 32'h00ffffff};
	// Fetch table: control, first and last offset, granule count; rotation only on 32bpp entries
	logic [31:0] ctls [6] = '{32'h00008027, 32'h00004007, 32'h00000004, 32'h00000022, 32'h00000021, 32'h00000000};
	logic [31:0] fo [6] = '{32'h00003fc0, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
	logic [31:0] lo [6] = '{32'h00000000, 32'h00003fc0, 32'h000003c0, 32'h0000ffc0, 32'h00000000, 32'h00000000};
	int cnt [6] = '{256, 256, 16, 1024, 0, 0};

	display_cursor_plane uut (.sys_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
		.vblank_start, .pipe_en, .dbuf_space, .dbuf_burst_room, .fetch_ack, .fetch_req, .fetch_addr, .pix_valid,
		.pix_in_cursor, .cur_texel, .under_pix, .under_sprite, .under_primary, .out_valid, .out_pix, .cursor_pos,
		.gamma_en, .csc_en, .rotate_180);

	// 20 MHz clock
	always #25 sys_clk = ~sys_clk;

	// Inputs change 1 ns after the edge so sampling never races
	task automatic tick(input int n = 1);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask

	// Idle cycle after each access keeps strobes from being reassigned in one step
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask

	task automatic rd(input logic [19:0] a, input logic [31:0] exp);
		reg_rd = 1'b1;
		reg_addr = a;
		tick();
		reg_rd = 1'b0;
		chk({31'h0, reg_rvalid}, 32'h1, "read valid");
		chk(reg_rdata, exp, "read data");
		tick();
	endtask

	task automatic vb();
		vblank_start = 1'b1;
		tick();
		vblank_start = 1'b0;
	endtask

	// Pipe off for a few cycles so armed control and other copies load at once
	task automatic cfg(input logic [31:0] c, input logic [31:0] b);
		wr(cursor_pkg::CTL_ADDR, c);
		wr(cursor_pkg::BASE_ADDR, b);
		pipe_en = 1'b0;
		tick(3);
		pipe_en = 1'b1;
		tick(2);
	endtask

	// One frame: no burst room first (space only when bursting), then full room with ack held, counting granules
	task automatic frame(input logic [31:0] first, input logic [31:0] last, input int n, input logic burst);
		int k = 0;
		dbuf_space = burst;
		vb();
		repeat (8) begin
			tick();
			if (fetch_req === 1'b1)
				k++;
		end
		chk(k, 0, "request without room");
		dbuf_space = 1'b1;
		dbuf_burst_room = 1'b1;
		fetch_ack = 1'b1;
		repeat (2200) begin
			tick();
			if (fetch_req === 1'b1) begin
				if (k == 0)
					chk(fetch_addr, first, "first address");
				if (k == n - 1)
					chk(fetch_addr, last, "last address");
				k++;
			end
		end
		chk(k, n, "granule count");
		fetch_ack = 1'b0;
		dbuf_space = 1'b0;
		dbuf_burst_room = 1'b0;
	endtask

	task automatic px(input logic [31:0] t, input logic [1:0] pl, input logic in, input logic [23:0] exp);
		pix_valid = 1'b1;
		pix_in_cursor = in;
		cur_texel = t;
		{under_primary, under_sprite} = pl;
		tick();
		pix_valid = 1'b0;
		chk({31'h0, out_valid}, 32'h1, "pixel valid");
		chk({8'h00, out_pix}, {8'h00, exp}, "pixel");
		tick();
	endtask

	initial begin
		int i;
		tick(16);
		rstn = 1'b1;
		tick();
		chk({3'h0, fetch_req, out_valid, reg_rvalid, cursor_pos}, 32'h0, "reset outputs");
		for (i = 0; i < 7; i++) begin
			rd(adr[i], 32'h00000000);
			wr(adr[i], 32'hffffffff);
			rd(adr[i], msk[i]);
		end
		wr(20'h7008c, 32'hffffffff);
		rd(20'h7008c, 32'h00000000);
		cfg(32'h00000000, 32'h00000000);
		wr(cursor_pkg::POS_ADDR, 32'h8abc8123);
		tick(3);
		chk({6'h00, cursor_pos}, {6'h00, 1'b1, 12'hfff, 1'b1, 12'hfff}, "position early");
		vb();
		tick(2);
		chk({6'h00, cursor_pos}, {6'h00, 1'b1, 12'habc, 1'b1, 12'h123}, "position");
		// Control waits for a base write even while the cursor is off
		wr(cursor_pkg::CTL_ADDR, 32'h05008027);
		tick(4);
		chk({29'h0, gamma_en, csc_en, rotate_180}, 32'h0, "unarmed control");
		wr(cursor_pkg::BASE_ADDR, 32'h00000000);
		tick(4);
		chk({29'h0, gamma_en, csc_en, rotate_180}, 32'h7, "armed control");
		wr(cursor_pkg::CTL_ADDR, 32'h00000027);
		vb();
		tick(4);
		chk({29'h0, gamma_en, csc_en, rotate_180}, 32'h7, "vblank without arm");
		for (i = 0; i < 6; i++) begin
			cfg(ctls[i], 32'h12345fff);
			chk({31'h0, rotate_180}, {31'h0, ctls[i][15]}, "rotation");
			chk({6'h00, cursor_pos}, {6'h00, 1'b1, 12'habc, 1'b1, 12'h123}, "rotated position");
			frame(32'h12345000 + fo[i], 32'h12345000 + lo[i], cnt[i], ctls[i][14]);
		end
		for (i = 0; i < 4; i++)
			wr(cursor_pkg::PAL_ADDR + 20'(4 * i), pal[i]);
		cfg(32'h00000027, 32'h00000000);
		px(32'hff445566, 2'b00, 1'b1, 24'h445566);
		px(32'h00445566, 2'b00, 1'b1, 24'h112233);
		px(32'hff445566, 2'b00, 1'b0, 24'h112233);
		under_pix = {10'h3fb, 10'h12c, 10'h040};
		px(32'h00445566, 2'b00, 1'b1, 24'h00ff40);
		under_pix = U;
		cfg(32'h00000527, 32'h00000000);
		px(32'h80aabbcc, 2'b01, 1'b1, 24'haabbcc);
		px(32'h7faabbcc, 2'b01, 1'b1, 24'h112233);
		cfg(32'h00000a27, 32'h00000000);
		px(32'hc0aabbcc, 2'b10, 1'b1, 24'haabbcc);
		px(32'hbfaabbcc, 2'b10, 1'b1, 24'h112233);
		cfg(32'h00000f27, 32'h00000000);
		px(32'hfeaabbcc, 2'b01, 1'b1, 24'h112233);
		px(32'hffaabbcc, 2'b10, 1'b1, 24'haabbcc);
		cfg(32'h00000007, 32'h00000000);
		px(32'hff123456, 2'b00, 1'b1, 24'h123456);
		px(32'h00000000, 2'b00, 1'b1, 24'h112233);
		px(32'h5a123456, 2'b00, 1'b1, 24'heeddcc);
		cfg(32'h00000024, 32'h00000000);
		px(32'h5a0f0f0f, 2'b00, 1'b1, 24'h1e2d3c);
		px(32'hffaabbcc, 2'b00, 1'b1, 24'haabbcc);
		cfg(32'h00000006, 32'h00000000);
		px(32'h00000002, 2'b00, 1'b1, 24'h708090);
		px(32'h00000003, 2'b00, 1'b1, 24'hffffff);
		cfg(32'h00000004, 32'h00000000);
		px(32'h00000000, 2'b00, 1'b1, 24'h102030);
		px(32'h00000002, 2'b00, 1'b1, 24'h112233);
		cfg(32'h00000005, 32'h00000000);
		px(32'h00000001, 2'b00, 1'b1, 24'h405060);
		px(32'h00000002, 2'b00, 1'b1, 24'h112233);
		px(32'h00000003, 2'b00, 1'b1, 24'heeddcc);
		cfg(32'h00000000, 32'h00000000);
		px(32'hff445566, 2'b00, 1'b1, 24'h112233);
		end_of_test();
	end
endmodule // tb_top
